// ---- rtl/host_gpio_port_defines.vh ----
`ifndef HOST_GPIO_PORT_DEFINES_VH
`define HOST_GPIO_PORT_DEFINES_VH

`define GPIO_ADDR_OUT_VALUE   8'h50
`define GPIO_ADDR_DIRECTION   8'h51
`define GPIO_ADDR_IN_LEVEL    8'h52
`define GPIO_ADDR_ALT_SELECT  8'h4F

`define GPIO_RST_OUT_VALUE    8'h00
`define GPIO_RST_DIRECTION    8'hFF
`define GPIO_RST_IN_LEVEL     8'h00
`define GPIO_RST_ALT_SELECT   2'h0

`define GPIO_PIN_ANTENNA      1
`define GPIO_PIN_SYNC         5
`define GPIO_PIN_RESERVED6    6
`define GPIO_PIN_IRQ          7
`define GPIO_ALT_PIN7_BIT     1
`define GPIO_ALT_PIN65_BIT    0
`define GPIO_ALT_PIN7_POS     7
`define GPIO_ALT_PIN65_POS    6

`define GPIO_IMPL_MASK        8'hFD
`define GPIO_ZERO_BYTE        8'h00
`define GPIO_ALT_PAD          6'h00
`define GPIO_PIN_COUNT        8
`define GPIO_PIN_RESERVED1    1
`define GPIO_DRIVE_ON         1'h1
`define GPIO_DRIVE_OFF        1'h0

`endif

// ---- rtl/gpio_pin_sync.v ----
`timescale 1ns/1ps
`include "host_gpio_port_defines.vh"

// two-stage synchroniser for the pin levels
module gpio_pin_sync
(
	input  wire       clk_sys_i,
	input  wire       rst_i,
	input  wire [7:0] pin_raw_i,
	output wire [7:0] pin_sync_o
);

	reg [7:0] stage1_q;
	reg [7:0] stage2_q;

	always @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			stage1_q <= `GPIO_RST_IN_LEVEL;
			stage2_q <= `GPIO_RST_IN_LEVEL;
		end
		else
		begin
			stage1_q <= pin_raw_i;
			stage2_q <= stage1_q;
		end
	end

	assign pin_sync_o = stage2_q;

endmodule

// ---- rtl/host_gpio_port.v ----
// Operation
// R1: output value register at 50h, reset 00h, drives pins configured as outputs
// R2: direction register at 51h; bit 0 means output, bit 1 means input
// R3: direction resets to FFh so every pin except antenna pin 1 starts as input
// R4: input level register at 52h is read-only, returns pin levels
// R5: bit 1 is reserved in all three registers; the direction register still stores bit 1 and reads it back
// R6: pin7 alternate select routes host interrupt request onto pin 7
// R7: pin6/pin5 alternate select puts transport sync on pin 5, reserves pin 6
// R8: pin 1 outputs antenna signal direction, 0 inbound, 1 outbound
// R9: pin levels pass a two-stage synchroniser before the input register
`timescale 1ns/1ps
`include "host_gpio_port_defines.vh"

module host_gpio_port
(
	input  wire       clk_sys_i,
	input  wire       rst_i,
	input  wire       reg_wr_i,
	input  wire [7:0] reg_addr_i,
	input  wire [7:0] reg_wdata_i,
	output reg  [7:0] reg_rdata_o,
	input  wire [7:0] pin_in_i,
	output reg  [7:0] pin_out_o,
	output reg  [7:0] pin_oe_o,
	input  wire       host_interrupt_request_i,
	input  wire       transport_sync_output_i,
	input  wire       antenna_dir_outbound_i,
	output wire [7:0] pin_input_level_o
);

	////////////////////////////////////////////////////////////////
	reg  [7:0] out_value_q;
	reg  [7:0] direction_q;
	reg  [7:0] in_level_q;
	reg  [1:0] alt_select_q;
	wire [7:0] pin_sync;
	wire [7:0] out_d;
	wire [7:0] oe_d;
	wire [7:0] gp_out;
	wire [7:0] gp_oe;
	wire [7:0] out_readback;
	wire [7:0] alt_readback;
	wire       wr_out_value;
	wire       wr_direction;
	wire       wr_alt_select;
	wire       alt_pin7_on;
	wire       alt_pin65_on;
	genvar     i;

	function hit;
		input [7:0] addr;
		input [7:0] target;
		begin
			hit = (addr == target);
		end
	endfunction

	////////////////////////////////////////////////////////////////
	gpio_pin_sync u_sync
	(
		.clk_sys_i  (clk_sys_i),
		.rst_i      (rst_i),
		.pin_raw_i  (pin_in_i),
		.pin_sync_o (pin_sync)
	); // R9

	// write strobes, one per writable register
	assign wr_out_value  = reg_wr_i && hit(reg_addr_i, `GPIO_ADDR_OUT_VALUE); // R1
	assign wr_direction  = reg_wr_i && hit(reg_addr_i, `GPIO_ADDR_DIRECTION); // R2
	assign wr_alt_select = reg_wr_i && hit(reg_addr_i, `GPIO_ADDR_ALT_SELECT);
	assign alt_pin7_on   = alt_select_q[`GPIO_ALT_PIN7_BIT];
	assign alt_pin65_on  = alt_select_q[`GPIO_ALT_PIN65_BIT];

	////////////////////////////////////////////////////////////////
	// output value register
	always @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			out_value_q <= `GPIO_RST_OUT_VALUE; // R1
		end
		else if (wr_out_value)
		begin
			out_value_q <= reg_wdata_i; // R1
		end
	end

	////////////////////////////////////////////////////////////////
	// direction register, all inputs out of reset
	always @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			direction_q <= `GPIO_RST_DIRECTION; // R3
		end
		else if (wr_direction)
		begin
			direction_q <= reg_wdata_i; // R2
		end
	end

	////////////////////////////////////////////////////////////////
	// alternate function select bits
	always @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			alt_select_q <= `GPIO_RST_ALT_SELECT;
		end
		else if (wr_alt_select)
		begin
			alt_select_q[`GPIO_ALT_PIN7_BIT]  <= reg_wdata_i[`GPIO_ALT_PIN7_POS];
			alt_select_q[`GPIO_ALT_PIN65_BIT] <= reg_wdata_i[`GPIO_ALT_PIN65_POS];
		end
	end

	////////////////////////////////////////////////////////////////
	// input level register, never written by the host
	always @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			in_level_q <= `GPIO_RST_IN_LEVEL;
		end
		else
		begin
			in_level_q <= pin_sync & `GPIO_IMPL_MASK; // R4 R5
		end
	end

	////////////////////////////////////////////////////////////////
	// registered pin drive
	always @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			pin_out_o <= `GPIO_ZERO_BYTE;
			pin_oe_o  <= `GPIO_ZERO_BYTE;
		end
		else
		begin
			pin_out_o <= out_d;
			pin_oe_o  <= oe_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// general purpose drive; reserved bit 1 never steers its pin
	generate
		for (i = 0; i < `GPIO_PIN_COUNT; i = i + 1)
		begin : g_gp
			if (i == `GPIO_PIN_RESERVED1)
			begin : g_gp_reserved
				assign gp_out[i] = `GPIO_DRIVE_OFF; // R5
				assign gp_oe[i]  = `GPIO_DRIVE_OFF; // R5
			end
			else
			begin : g_gp_used
				assign gp_out[i] = out_value_q[i]; // R1
				assign gp_oe[i]  = ~direction_q[i]; // R2
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// per-pin drive: alternate functions override general purpose
	generate
		for (i = 0; i < `GPIO_PIN_COUNT; i = i + 1)
		begin : g_pin
			if (i == `GPIO_PIN_ANTENNA)
			begin : g_antenna
				assign out_d[i] = antenna_dir_outbound_i; // R8
				assign oe_d[i]  = `GPIO_DRIVE_ON; // R8
			end
			else if (i == `GPIO_PIN_IRQ)
			begin : g_irq
				assign out_d[i] = alt_pin7_on ? host_interrupt_request_i : gp_out[i]; // R6
				assign oe_d[i]  = alt_pin7_on ? `GPIO_DRIVE_ON : gp_oe[i]; // R6
			end
			else if (i == `GPIO_PIN_SYNC)
			begin : g_sync
				assign out_d[i] = alt_pin65_on ? transport_sync_output_i : gp_out[i]; // R7
				assign oe_d[i]  = alt_pin65_on ? `GPIO_DRIVE_ON : gp_oe[i]; // R7
			end
			else if (i == `GPIO_PIN_RESERVED6)
			begin : g_reserved
				assign out_d[i] = alt_pin65_on ? `GPIO_DRIVE_OFF : gp_out[i]; // R7
				assign oe_d[i]  = alt_pin65_on ? `GPIO_DRIVE_OFF : gp_oe[i]; // R7
			end
			else
			begin : g_plain
				assign out_d[i] = gp_out[i]; // R1
				assign oe_d[i]  = gp_oe[i]; // R2
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// readback views; reserved bits read zero
	assign out_readback = gp_out; // R5
	assign alt_readback = {alt_select_q, `GPIO_ALT_PAD};

	////////////////////////////////////////////////////////////////
	// read mux; unmapped addresses read zero
	always @*
	begin
		case (reg_addr_i)
			`GPIO_ADDR_OUT_VALUE:
			begin
				reg_rdata_o = out_readback; // R5
			end
			`GPIO_ADDR_DIRECTION:
			begin
				reg_rdata_o = direction_q; // R3
			end
			`GPIO_ADDR_IN_LEVEL:
			begin
				reg_rdata_o = in_level_q; // R4
			end
			`GPIO_ADDR_ALT_SELECT:
			begin
				reg_rdata_o = alt_readback;
			end
			default:
			begin
				reg_rdata_o = `GPIO_ZERO_BYTE;
			end
		endcase
	end

	assign pin_input_level_o = in_level_q;

endmodule

// ---- tb/host_gpio_port_asserts.sv ----
`timescale 1ns/1ps
module host_gpio_port_asserts(input wire logic clk_sys_i,rst_i,reg_wr_i,antenna_dir_outbound_i,
	input wire logic [7:0] reg_addr_i,reg_wdata_i,reg_rdata_o,pin_in_i,pin_out_o,pin_oe_o,pin_input_level_o);
wire w50=reg_wr_i&&reg_addr_i==8'h50;
wire w51=reg_wr_i&&reg_addr_i==8'h51;
default clocking @(posedge clk_sys_i); endclocking
default disable iff (rst_i);
a_pin1_drive: assert property(!$past(rst_i)|->pin_oe_o[1]&&pin_out_o[1]==$past(antenna_dir_outbound_i))
	else $error("p1");
a_out_store: assert property(w50|=>reg_addr_i!=8'h50||reg_rdata_o==($past(reg_wdata_i)&8'hFD))
	else $error("ov");
a_dir_store: assert property(w51|=>reg_addr_i!=8'h51||reg_rdata_o==$past(reg_wdata_i))
	else $error("dv");
a_level_ro: assert property(reg_addr_i==8'h52|->reg_rdata_o==pin_input_level_o)
	else $error("il");
a_level_sync: assert property(!$past(rst_i,4)|->pin_input_level_o==($past(pin_in_i,3)&8'hFD))
	else $error("sy");
a_dir_drive: assert property(w51 ##1 !reg_wr_i|=>pin_oe_o[4:2]==~$past(reg_wdata_i[4:2],2))
	else $error("oe");
a_out_drive: assert property(w50 ##1 !reg_wr_i|=>!pin_oe_o[3]||pin_out_o[3]==$past(reg_wdata_i[3],2))
	else $error("od");
a_reset_idle: assert property($fell(rst_i)|->pin_oe_o==8'h00&&pin_out_o==8'h00)
	else $error("rs");
endmodule
bind host_gpio_port host_gpio_port_asserts chk(.*);

// ---- tb/gpio_board_model.sv ----
`timescale 1ns/1ps
module gpio_board_model(input wire logic [7:0] out_i,oe_i,ext_i,output wire logic [7:0] lvl_o);
// driven pins follow the device, the rest the board
assign lvl_o=(oe_i&out_i)|(~oe_i&ext_i);
endmodule

// ---- tb/host_gpio_port_bench.sv ----
`timescale 1ns/1ps
`define CHK(a,b) begin cmp_count++; if((a)!==(b)) begin error_cnt++; $display("Error %0t %h",$time,a); end end
module host_gpio_port_bench;
logic clk_sys_i=0,rst_i=1,reg_wr_i=0,host_interrupt_request_i=1,transport_sync_output_i=1,antenna_dir_outbound_i=1;
logic [7:0] reg_addr_i=0,reg_wdata_i=0,ext_q=8'hA6;
wire [7:0] reg_rdata_o,pin_in_i,pin_out_o,pin_oe_o,pin_input_level_o;
int error_cnt=0,cmp_count=0;
host_gpio_port dut(.*);
gpio_board_model board(.out_i(pin_out_o),.oe_i(pin_oe_o),.ext_i(ext_q),.lvl_o(pin_in_i));
initial forever #2.5 clk_sys_i=~clk_sys_i;
task wr(logic [7:0] a,d); @(posedge clk_sys_i); reg_wr_i<=1; reg_addr_i<=a; reg_wdata_i<=d;
	@(posedge clk_sys_i); reg_wr_i<=0; repeat(4) @(posedge clk_sys_i); #1; endtask
task rd(logic [7:0] a,e); @(posedge clk_sys_i); reg_addr_i<=a; #1 `CHK(reg_rdata_o,e) endtask
task summarize; $display("errors %0d compares %0d",error_cnt,cmp_count);
	if(error_cnt==0&&cmp_count>0) $display("*** PASS ***"); else $display("*** FAIL ***"); $finish; endtask
initial begin
	repeat(16) @(posedge clk_sys_i); rst_i<=0;
	rd(8'h51,8'hFF);
	`CHK(pin_oe_o,8'h02)
	wr(8'h51,8'h00); wr(8'h50,8'hFF); rd(8'h50,8'hFD);
	`CHK({pin_oe_o,pin_out_o},16'hFFFF)
	wr(8'h51,8'hFF); wr(8'h52,8'h00); rd(8'h52,8'hA4);
	`CHK(pin_input_level_o,8'hA4)
	@(posedge clk_sys_i); antenna_dir_outbound_i<=0;
	wr(8'h4F,8'hC0); wr(8'h51,8'h00); wr(8'h50,8'h00);
	`CHK({pin_out_o&8'hA2,pin_oe_o&8'h40},16'hA000)
	@(posedge clk_sys_i); host_interrupt_request_i<=0; transport_sync_output_i<=0;
	repeat(2) @(posedge clk_sys_i); #1 `CHK(pin_out_o&8'hA0,8'h00)
	summarize;
end
endmodule
